//--- core/mei_event_irq.sv
`timescale 1ns/100ps
`default_nettype none
module mei_event_irq
    import mei_pkg::*;
#(
    parameter int W          = 16,
    parameter int SAMPLE_DIV = SAMPLE_CYCLES
)
(
    input  wire logic         REF_CLK_I,
    input  wire logic         RST_I,
    input  wire logic         WAKE_I,
    input  wire logic [W-1:0] X_I,
    input  wire logic [W-1:0] Y_I,
    input  wire logic [W-1:0] Z_I,
    input  wire logic [7:0]   EVENT_MASK_I,
    input  wire logic         DROP_IRQ_EN_I,
    input  wire logic         DROP_SUM_SEL_I,
    input  wire logic [2:0]   TAP_AXIS_SEL_I,
    input  wire logic         SAMPLE_IRQ_RATE_SEL_I,
    input  wire logic [3:0]   LOWPASS_BW_SEL_I,
    input  wire logic [W-1:0] UPDOWN_Z_THRESH_I,
    input  wire logic [W-1:0] UPDOWN_X_THRESH_I,
    input  wire logic [W-1:0] RIGHTLEFT_Z_THRESH_I,
    input  wire logic [W-1:0] RIGHTLEFT_Y_THRESH_I,
    input  wire logic [W-1:0] FACE_Z_THRESH_I,
    input  wire logic [W-1:0] SHAKE_THRESH_I,
    input  wire logic [W-1:0] DROP_THRESH_I,
    input  wire logic [W-1:0] TAP_THRESH_I,
    input  wire logic         ADDR_MATCH_I,
    input  wire logic         READ_ACCESS_I,
    input  wire logic         STATUS_READ_I,
    input  wire logic         STOP_SEEN_I,
    output logic              EVENT_IRQ_N_O,
    output logic              TAP_FLAG_O,
    output logic              SHAKE_FLAG_O,
    output logic              DROP_FLAG_O,
    output logic [2:0]        ORIENT_CODE_O,
    output logic [1:0]        FACE_CODE_O,
    output logic              SAMPLE_TICK_O,
    output logic [W-1:0]      X_DATA_O,
    output logic [W-1:0]      Y_DATA_O,
    output logic [W-1:0]      Z_DATA_O
);
    // magnitude and sum widths only serve these sample sizes
    if (W < 4 || W > 24)
    begin : g_width_check
        $error("mei_event_irq: sample width out of range");
    end
    // a divider below 2 would tick on every edge
    if (SAMPLE_DIV < 2)
    begin : g_div_check
        $error("mei_event_irq: sample divider too small");
    end

    // divider width follows the sample period
    localparam int CW = $clog2(SAMPLE_DIV);

    // pin-side inputs, two-stage synchronisers
    logic [1:0] wake_sync_reg;
    logic [1:0] stop_sync_reg;
    logic [1:0] am_sync_reg;
    logic [1:0] rd_sync_reg;
    logic [1:0] st_sync_reg;
    logic       am_d_reg;
    logic       rd_d_reg;
    logic       st_d_reg;
    logic       stop_d_reg;
    always_ff @(posedge REF_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            wake_sync_reg <= 2'h0;
            stop_sync_reg <= 2'h0;
            am_sync_reg   <= 2'h0;
            rd_sync_reg   <= 2'h0;
            st_sync_reg   <= 2'h0;
            am_d_reg      <= 1'b0;
            rd_d_reg      <= 1'b0;
            st_d_reg      <= 1'b0;
            stop_d_reg    <= 1'b0;
        end
        else
        begin
            wake_sync_reg <= {wake_sync_reg[0], WAKE_I};
            stop_sync_reg <= {stop_sync_reg[0], STOP_SEEN_I};
            am_sync_reg   <= {am_sync_reg[0], ADDR_MATCH_I};
            rd_sync_reg   <= {rd_sync_reg[0], READ_ACCESS_I};
            st_sync_reg   <= {st_sync_reg[0], STATUS_READ_I};
            am_d_reg      <= am_sync_reg[1];
            rd_d_reg      <= rd_sync_reg[1];
            st_d_reg      <= st_sync_reg[1];
            stop_d_reg    <= stop_sync_reg[1];
        end
    end

    // edge detectors read only the second stage and its delayed copy
    logic wake;
    logic stop_rise;
    logic rd_rise;
    logic st_rise;
    assign wake      = wake_sync_reg[1];
    assign stop_rise = stop_sync_reg[1] & ~stop_d_reg;
    assign rd_rise   = rd_sync_reg[1] & ~rd_d_reg;
    assign st_rise   = st_sync_reg[1] & ~st_d_reg;

    // settings captured only while in standby, so a wake write is inert
    logic [7:0]   mask_reg;
    logic         drop_en_reg;
    logic         drop_sum_reg;
    logic [2:0]   tap_sel_reg;
    logic         rate_sel_reg;
    logic [3:0]   bw_reg;
    logic [W-1:0] udz_reg;
    logic [W-1:0] udx_reg;
    logic [W-1:0] rlz_reg;
    logic [W-1:0] rly_reg;
    logic [W-1:0] fbz_reg;
    logic [W-1:0] shk_reg;
    logic [W-1:0] drp_reg;
    logic [W-1:0] tap_reg;
    // zero masks keep every source quiet until the host programs them
    always_ff @(posedge REF_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            mask_reg     <= MASK_RESET;
            drop_en_reg  <= 1'b0;
            drop_sum_reg <= 1'b0;
            tap_sel_reg  <= 3'h0;
            rate_sel_reg <= 1'b0;
            bw_reg       <= BW_RESET;
            udz_reg      <= W'(THRESH_RESET);
            udx_reg      <= W'(THRESH_RESET);
            rlz_reg      <= W'(THRESH_RESET);
            rly_reg      <= W'(THRESH_RESET);
            fbz_reg      <= W'(THRESH_RESET);
            shk_reg      <= W'(THRESH_RESET);
            drp_reg      <= W'(THRESH_RESET);
            tap_reg      <= W'(THRESH_RESET);
        end
        else if (!wake)
        begin
            mask_reg     <= EVENT_MASK_I;
            drop_en_reg  <= DROP_IRQ_EN_I;
            drop_sum_reg <= DROP_SUM_SEL_I;
            tap_sel_reg  <= TAP_AXIS_SEL_I;
            rate_sel_reg <= SAMPLE_IRQ_RATE_SEL_I;
            bw_reg       <= LOWPASS_BW_SEL_I;
            udz_reg      <= UPDOWN_Z_THRESH_I;
            udx_reg      <= UPDOWN_X_THRESH_I;
            rlz_reg      <= RIGHTLEFT_Z_THRESH_I;
            rly_reg      <= RIGHTLEFT_Y_THRESH_I;
            fbz_reg      <= FACE_Z_THRESH_I;
            shk_reg      <= SHAKE_THRESH_I;
            drp_reg      <= DROP_THRESH_I;
            tap_reg      <= TAP_THRESH_I;
        end
    end

    // sample period timer; halted in standby
    logic [CW-1:0] div_reg;
    logic          tick;
    assign tick = wake && (div_reg == CW'(SAMPLE_DIV - 1));
    always_ff @(posedge REF_CLK_I or posedge RST_I)
    begin
        if (RST_I)
            div_reg <= '0;
        else if (!wake || tick)
            div_reg <= '0;
        else
            div_reg <= div_reg + 1'b1;
    end

    // bandwidth pacing: one sample interrupt per 2^n samples, n being the low three bits of bw
    logic [8:0] bw_cnt_reg;
    logic       bw_due;
    assign bw_due = (bw_cnt_reg >= ((9'h1 << bw_reg[2:0]) - 9'h1));
    always_ff @(posedge REF_CLK_I or posedge RST_I)
    begin
        if (RST_I)
            bw_cnt_reg <= 9'h0;
        else if (!wake || (tick && bw_due))
            bw_cnt_reg <= 9'h0;
        else if (tick)
            bw_cnt_reg <= bw_cnt_reg + 9'h1;
    end

    // magnitudes, one bit wider so the most negative value fits
    logic [W:0]   ax;
    logic [W:0]   ay;
    logic [W:0]   az;
    // two more bits for the sum, else three large axes wrap to a drop
    logic [W+1:0] sum;
    assign ax  = X_I[W-1] ? (W+1)'(-$signed(X_I)) : {1'b0, X_I};
    assign ay  = Y_I[W-1] ? (W+1)'(-$signed(Y_I)) : {1'b0, Y_I};
    assign az  = Z_I[W-1] ? (W+1)'(-$signed(Z_I)) : {1'b0, Z_I};
    assign sum = (W+2)'(ax) + (W+2)'(ay) + (W+2)'(az);

    // thresholds are absolute magnitude levels; the dead band between codes reports unknown, with no hysteresis
    logic up;
    logic down;
    logic right;
    logic left;
    logic front;
    logic back;
    assign up    = (az < {1'b0, udz_reg}) && (ax > {1'b0, udx_reg})
                   && X_I[W-1];
    assign down  = (az < {1'b0, udz_reg}) && (ax > {1'b0, udx_reg})
                   && !X_I[W-1] && (X_I != '0);
    assign right = (az < {1'b0, rlz_reg}) && (ay > {1'b0, rly_reg})
                   && Y_I[W-1];
    assign left  = (az < {1'b0, rlz_reg}) && (ay > {1'b0, rly_reg})
                   && !Y_I[W-1] && (Y_I != '0);
    assign front = !Z_I[W-1] && (az > {1'b0, fbz_reg});
    assign back  = Z_I[W-1] && (az > {1'b0, fbz_reg});

    // overlapping portrait and landscape hits report unknown
    logic [2:0] orient;
    logic [1:0] face;
    always_comb
    begin
        orient = ORIENT_UNKNOWN;
        if (up && !left && !right)
            orient = ORIENT_UP;
        else if (down && !left && !right)
            orient = ORIENT_DOWN;
        else if (left && !up && !down)
            orient = ORIENT_LEFT;
        else if (right && !up && !down)
            orient = ORIENT_RIGHT;
        face = front ? FACE_FRONT : (back ? FACE_BACK : FACE_UNKNOWN);
    end

    // event detectors; the shake enables double as its axis select
    logic shake;
    logic drop;
    logic tap;
    assign shake = (mask_reg[MSK_SHAKE_X] && ax > {1'b0, shk_reg})
                || (mask_reg[MSK_SHAKE_Y] && ay > {1'b0, shk_reg})
                || (mask_reg[MSK_SHAKE_Z] && az > {1'b0, shk_reg});
    assign drop  = drop_sum_reg ? (sum < {2'b0, drp_reg})
                 : (ax < {1'b0, drp_reg}) && (ay < {1'b0, drp_reg})
                   && (az < {1'b0, drp_reg});
    assign tap   = (tap_sel_reg[0] && ax > {1'b0, tap_reg})
                || (tap_sel_reg[1] && ay > {1'b0, tap_reg})
                || (tap_sel_reg[2] && az > {1'b0, tap_reg});

    // orientation codes overwrite each sample
    logic orient_chg;
    logic face_chg;
    assign orient_chg = tick && (orient != ORIENT_CODE_O);
    assign face_chg   = tick && (face != FACE_CODE_O);
    always_ff @(posedge REF_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            ORIENT_CODE_O <= ORIENT_UNKNOWN;
            FACE_CODE_O   <= FACE_UNKNOWN;
        end
        else if (tick)
        begin
            ORIENT_CODE_O <= orient;
            FACE_CODE_O   <= face;
        end
    end

    // sample data refresh needs a stop since the previous refresh
    logic stop_pend_reg;
    always_ff @(posedge REF_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            stop_pend_reg <= 1'b1;
            X_DATA_O      <= '0;
            Y_DATA_O      <= '0;
            Z_DATA_O      <= '0;
        end
        else if (tick && (stop_pend_reg || stop_rise))
        begin
            stop_pend_reg <= 1'b0;
            X_DATA_O      <= X_I;
            Y_DATA_O      <= Y_I;
            Z_DATA_O      <= Z_I;
        end
        else if (stop_rise)
            stop_pend_reg <= 1'b1;
    end

    // sticky flags, gated by enables; a new event beats the read clear
    logic tap_ev;
    logic shake_ev;
    logic drop_ev;
    assign tap_ev   = tick && tap && mask_reg[MSK_TAP];
    assign shake_ev = tick && shake;
    assign drop_ev  = tick && drop && drop_en_reg;
    always_ff @(posedge REF_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            TAP_FLAG_O   <= 1'b0;
            SHAKE_FLAG_O <= 1'b0;
            DROP_FLAG_O  <= 1'b0;
        end
        else
        begin
            TAP_FLAG_O   <= tap_ev | (TAP_FLAG_O & ~st_rise);
            SHAKE_FLAG_O <= shake_ev | (SHAKE_FLAG_O & ~st_rise);
            DROP_FLAG_O  <= drop_ev | (DROP_FLAG_O & ~st_rise);
        end
    end

    // sample update source and the collected interrupt request
    logic sample_ev;
    logic irq_set;
    assign sample_ev = tick && mask_reg[MSK_SAMPLE]
                       && (!rate_sel_reg || bw_due);
    assign irq_set   = tap_ev || shake_ev || drop_ev || sample_ev
                    || (orient_chg && mask_reg[MSK_ORIENT])
                    || (face_chg && mask_reg[MSK_FACE]);

    // pin held low until a read after address match or standby; set wins
    logic irq_clr;
    assign irq_clr = am_d_reg && rd_rise;
    always_ff @(posedge REF_CLK_I or posedge RST_I)
    begin
        if (RST_I)
            EVENT_IRQ_N_O <= 1'b1;
        else if (!wake)
            EVENT_IRQ_N_O <= 1'b1;
        else if (irq_set)
            EVENT_IRQ_N_O <= 1'b0;
        else if (irq_clr)
            EVENT_IRQ_N_O <= 1'b1;
    end

    // tick leaves as a strobe for the checker, not as data
    assign SAMPLE_TICK_O = tick;
endmodule // mei_event_irq
`default_nettype wire

//--- core/mei_pkg.sv
package mei_pkg;
    localparam int          SAMPLE_RATE_HZ = 1024;
    localparam int          CLK_HZ         = 20000000;
    // 19531 cycles; remainder accepted, rate error well under 0.01 %
    localparam int          SAMPLE_CYCLES  = CLK_HZ / SAMPLE_RATE_HZ;
    localparam logic [2:0]  ORIENT_UNKNOWN = 3'h0;
    localparam logic [2:0]  ORIENT_LEFT    = 3'h1;
    localparam logic [2:0]  ORIENT_RIGHT   = 3'h2;
    localparam logic [2:0]  ORIENT_DOWN    = 3'h5;
    localparam logic [2:0]  ORIENT_UP      = 3'h6;
    localparam logic [1:0]  FACE_UNKNOWN   = 2'h0;
    localparam logic [1:0]  FACE_FRONT     = 2'h1;
    localparam logic [1:0]  FACE_BACK      = 2'h2;
    // event mask bit positions
    localparam int          MSK_FACE       = 0;
    localparam int          MSK_ORIENT     = 1;
    localparam int          MSK_SHAKE_X    = 2;
    localparam int          MSK_SHAKE_Y    = 3;
    localparam int          MSK_SHAKE_Z    = 4;
    localparam int          MSK_TAP        = 5;
    localparam int          MSK_SAMPLE     = 6;
    localparam logic [7:0]  MASK_RESET     = 8'h00;
    localparam logic [15:0] THRESH_RESET   = 16'h0000;
    localparam logic [3:0]  BW_RESET       = 4'h0;
endpackage : mei_pkg

//--- dv/mei_event_irq_checker.sv
`timescale 1ns/100ps
`default_nettype none
module mei_event_irq_checker
    import mei_pkg::*;
#(
    parameter int W = 16
)
(
    input wire logic         REF_CLK_I,
    input wire logic         RST_I,
    input wire logic         WAKE_I,
    input wire logic [W-1:0] X_I,
    input wire logic [7:0]   EVENT_MASK_I,
    input wire logic [2:0]   TAP_AXIS_SEL_I,
    input wire logic [W-1:0] TAP_THRESH_I,
    input wire logic         ADDR_MATCH_I,
    input wire logic         READ_ACCESS_I,
    input wire logic         STATUS_READ_I,
    input wire logic         EVENT_IRQ_N_O,
    input wire logic         TAP_FLAG_O,
    input wire logic         SHAKE_FLAG_O,
    input wire logic         DROP_FLAG_O,
    input wire logic [2:0]   ORIENT_CODE_O,
    input wire logic [1:0]   FACE_CODE_O,
    input wire logic         SAMPLE_TICK_O,
    input wire logic [W-1:0] X_DATA_O
);
    // one clock domain, so clocking and reset are given once
    default clocking cb @(posedge REF_CLK_I);
    endclocking
    default disable iff (RST_I);

    a_standby_quiet: assert property (
        !WAKE_I [*5] |-> !SAMPLE_TICK_O && EVENT_IRQ_N_O)
        else $error("tick or interrupt while in standby");
    a_tick_pulse: assert property (
        SAMPLE_TICK_O |=> !SAMPLE_TICK_O [*8])
        else $error("sample tick too wide or too close");
    a_tap_sets: assert property (
        SAMPLE_TICK_O && EVENT_MASK_I[MSK_TAP] && TAP_AXIS_SEL_I[0]
        && !X_I[W-1] && X_I > TAP_THRESH_I
        |=> TAP_FLAG_O && !EVENT_IRQ_N_O)
        else $error("tap event did not set flag and interrupt");
    a_no_tap: assert property (
        SAMPLE_TICK_O && !EVENT_MASK_I[MSK_TAP] && !TAP_FLAG_O
        |=> !TAP_FLAG_O)
        else $error("masked tap event set its flag");
    // the read pin stays high for many cycles, so four low samples
    // mean no read edge is still in the synchroniser
    a_flag_hold: assert property (
        !STATUS_READ_I [*4] |-> !$fell(TAP_FLAG_O)
        && !$fell(SHAKE_FLAG_O) && !$fell(DROP_FLAG_O))
        else $error("event flag dropped without a status read");
    a_read_clears: assert property (
        $rose(STATUS_READ_I) && !WAKE_I
        |-> ##[2:4] !(TAP_FLAG_O || SHAKE_FLAG_O || DROP_FLAG_O))
        else $error("status read did not clear the flags");
    a_irq_clear: assert property (
        ADDR_MATCH_I [*4] ##1 $rose(READ_ACCESS_I)
        |-> ##[2:4] EVENT_IRQ_N_O)
        else $error("addressed read did not release interrupt");
    a_irq_hold: assert property (
        (WAKE_I && !READ_ACCESS_I) [*4] ##0 !EVENT_IRQ_N_O
        |=> !EVENT_IRQ_N_O)
        else $error("interrupt released without a read access");
    a_code_steady: assert property (
        !SAMPLE_TICK_O
        |=> $stable(ORIENT_CODE_O) && $stable(FACE_CODE_O))
        else $error("orientation code moved between samples");
    a_data_steady: assert property (
        !SAMPLE_TICK_O |=> $stable(X_DATA_O))
        else $error("sample data moved between samples");
endmodule // mei_event_irq_checker

bind mei_event_irq mei_event_irq_checker #(.W(W)) mei_event_irq_checker_i (
    .REF_CLK_I(REF_CLK_I), .RST_I(RST_I), .WAKE_I(WAKE_I), .X_I(X_I),
    .EVENT_MASK_I(EVENT_MASK_I), .TAP_AXIS_SEL_I(TAP_AXIS_SEL_I),
    .TAP_THRESH_I(TAP_THRESH_I), .ADDR_MATCH_I(ADDR_MATCH_I),
    .READ_ACCESS_I(READ_ACCESS_I), .STATUS_READ_I(STATUS_READ_I),
    .EVENT_IRQ_N_O(EVENT_IRQ_N_O), .TAP_FLAG_O(TAP_FLAG_O),
    .SHAKE_FLAG_O(SHAKE_FLAG_O), .DROP_FLAG_O(DROP_FLAG_O),
    .ORIENT_CODE_O(ORIENT_CODE_O), .FACE_CODE_O(FACE_CODE_O),
    .SAMPLE_TICK_O(SAMPLE_TICK_O), .X_DATA_O(X_DATA_O));
`default_nettype wire

//--- dv/mei_host.sv
`timescale 1ns/100ps
`default_nettype none
module mei_host
(
    input  wire logic clk_i,
    output logic      addr_match_o,
    output logic      read_access_o,
    output logic      status_read_o,
    output logic      stop_seen_o
);
    // bus idle at start
    initial {addr_match_o, read_access_o, status_read_o, stop_seen_o} = 4'h0;

    // one frame paced by the 400 ns bus clock; each step outlasts
    // the three-edge synchronisers on the device side
    task automatic frame(input logic adr, input logic sts);
        @(posedge clk_i);
        #5;
        addr_match_o = adr;
        #400;
        read_access_o = 1'h1;
        status_read_o = sts;
        #400;
        {addr_match_o, read_access_o, status_read_o} = 3'h0;
        #400;
        stop_seen_o = 1'h1;
        #400;
        stop_seen_o = 1'h0;
    endtask
endmodule // mei_host
`default_nettype wire

//--- dv/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top
    import mei_pkg::*;
();
    logic        clk = 1'h0;
    logic        rst = 1'h1;
    logic        wake = 1'h0;
    logic        den = 1'h0;
    logic        dsum = 1'h0;
    logic [2:0]  tsel = 3'h1;
    logic [7:0]  msk = 8'h00;
    logic [15:0] x = 16'h0000, y = 16'h0000, z = 16'h0000;
    logic [15:0] th [6] = '{16'h0320, 16'h0064, 16'h012c, 16'h03e8,
                            16'h0032, 16'h000a};
    logic        irq_n, tapf, shf, drf, tick, am, ra, sr, sp;
    logic [2:0]  oc;
    logic [1:0]  fc;
    logic [15:0] xd, yd, zd;
    logic        rsel = 1'h0;
    logic [3:0]  bw = 4'h0;
    int          num_errors = 0;
    int          n_compared = 0;
    logic [47:0] ov [7] = '{48'hfe0c_0000_0000, 48'h01f4_0000_0000,
        48'h0000_fe0c_0000, 48'h0000_01f4_0000, 48'hffce_0000_0000,
        48'h0000_0000_03e8, 48'h0000_0000_fc18};
    logic [4:0]  oe [7] = '{{ORIENT_UP, FACE_UNKNOWN},
        {ORIENT_DOWN, FACE_UNKNOWN}, {ORIENT_RIGHT, FACE_UNKNOWN},
        {ORIENT_LEFT, FACE_UNKNOWN}, {ORIENT_UNKNOWN, FACE_UNKNOWN},
        {ORIENT_UNKNOWN, FACE_FRONT}, {ORIENT_UNKNOWN, FACE_BACK}};

    // short sample period keeps the run small
    mei_event_irq #(.SAMPLE_DIV(20)) mei_event_irq_i (
        .REF_CLK_I(clk), .RST_I(rst), .WAKE_I(wake), .X_I(x), .Y_I(y),
        .Z_I(z), .EVENT_MASK_I(msk), .DROP_IRQ_EN_I(den),
        .DROP_SUM_SEL_I(dsum), .TAP_AXIS_SEL_I(tsel),
        .SAMPLE_IRQ_RATE_SEL_I(rsel), .LOWPASS_BW_SEL_I(bw),
        .UPDOWN_Z_THRESH_I(th[0]), .UPDOWN_X_THRESH_I(th[1]),
        .RIGHTLEFT_Z_THRESH_I(th[0]), .RIGHTLEFT_Y_THRESH_I(th[1]),
        .FACE_Z_THRESH_I(th[2]), .SHAKE_THRESH_I(th[3]),
        .DROP_THRESH_I(th[4]), .TAP_THRESH_I(th[5]),
        .ADDR_MATCH_I(am), .READ_ACCESS_I(ra), .STATUS_READ_I(sr),
        .STOP_SEEN_I(sp), .EVENT_IRQ_N_O(irq_n), .TAP_FLAG_O(tapf),
        .SHAKE_FLAG_O(shf), .DROP_FLAG_O(drf), .ORIENT_CODE_O(oc),
        .FACE_CODE_O(fc), .SAMPLE_TICK_O(tick), .X_DATA_O(xd),
        .Y_DATA_O(yd), .Z_DATA_O(zd));
    mei_host mei_host_i (.clk_i(clk), .addr_match_o(am),
        .read_access_o(ra), .status_read_o(sr), .stop_seen_o(sp));

    // 20 MHz reference clock
    always #25 clk = ~clk;

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #5;
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_compared++;
        if (g !== e)
        begin
            num_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask
    // settings are only taken in standby, so drop wake around them
    task automatic cfg(input logic [7:0] m, input logic d, input logic s);
        wake = 1'h0;
        cyc(5);
        msk = m;
        den = d;
        dsum = s;
        cyc(1);
        wake = 1'h1;
        cyc(3);
    endtask
    // bounded wait for a tick, then one edge for the answer
    task automatic wt;
        for (int i = 0; i < 40 && tick !== 1'h1; i++)
            cyc(1);
        cyc(1);
    endtask
    task automatic clr;
        wake = 1'h0;
        cyc(5);
        mei_host_i.frame(1'h1, 1'h1);
        chk({tapf, shf, drf}, 3'h0);
    endtask

    task automatic t_tap;
        cfg(8'h20, 1'h0, 1'h0);
        x = 16'h0064;
        wt();
        chk({tapf, irq_n}, 2'h2);
        x = 16'h0000;
        mei_host_i.frame(1'h0, 1'h0);
        chk(irq_n, 1'h0);
        mei_host_i.frame(1'h1, 1'h0);
        chk({tapf, irq_n}, 2'h3);
        clr();
        $display("tap test done");
    endtask
    // shake and tap at once, then drop by both criteria
    task automatic t_multi;
        x = 16'h07d0;
        cfg(8'h24, 1'h1, 1'h0);
        wt();
        chk({tapf, shf, drf}, 3'h6);
        {x, y, z} = {3{16'h000a}};
        wt();
        chk(drf, 1'h1);
        clr();
        {x, y, z} = {3{16'h0014}};
        cfg(8'h00, 1'h1, 1'h1);
        wt();
        chk(drf, 1'h0);
        {x, y, z} = {3{16'h000a}};
        wt();
        chk(drf, 1'h1);
        clr();
        $display("shake drop test done");
    endtask
    task automatic t_orient;
        cfg(8'h02, 1'h0, 1'h0);
        for (int i = 0; i < 7; i++)
        begin
            {x, y, z} = ov[i];
            wt();
            chk({oc, fc}, oe[i]);
        end
        chk(irq_n, 1'h0);
        $display("orientation test done");
    endtask
    // count ticks awake and in standby
    task automatic t_sample;
        logic [15:0] n;
        cfg(8'h40, 1'h0, 1'h0);
        n = '0;
        repeat (200)
        begin
            cyc(1);
            n += tick;
        end
        chk(n, 16'h000a);
        chk(irq_n, 1'h0);
        wake = 1'h0;
        cyc(5);
        n = '0;
        repeat (200)
        begin
            cyc(1);
            n += tick;
        end
        chk({n[14:0], irq_n}, 16'h0001);
        $display("sample test done");
    endtask
    // data words move only after a bus stop
    task automatic t_stop;
        {x, y, z} = {16'h0064, 16'h00c8, 16'h012c};
        cfg(8'h00, 1'h0, 1'h0);
        mei_host_i.frame(1'h0, 1'h0);
        wt();
        wt();
        chk(xd, 16'h0064);
        chk(yd, 16'h00c8);
        chk(zd, 16'h012c);
        chk(tapf, 1'h0);
        x = 16'h0065;
        wt();
        wt();
        chk(xd, 16'h0064);
        mei_host_i.frame(1'h0, 1'h0);
        wt();
        wt();
        chk(xd, 16'h0065);
        $display("stop test done");
    endtask

    // rate select with bandwidth 3: sample interrupt on every 8th tick
    task automatic t_rate;
        logic [15:0] n;
        rsel = 1'h1;
        bw = 4'h3;
        cfg(8'h40, 1'h0, 1'h0);
        n = '0;
        for (int i = 0; i < 400 && irq_n !== 1'h0; i++)
        begin
            n += tick;
            cyc(1);
        end
        chk(n, 16'h0008);
        $display("rate test done");
    endtask

    task automatic end_sim;
        $display("compared %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // main sequence
    initial
    begin
        cyc(20);
        rst = 1'h0;
        cyc(2);
        chk({irq_n, tapf, shf, drf, oc}, 7'h40);
        t_tap();
        t_multi();
        t_orient();
        t_sample();
        t_stop();
        t_rate();
        end_sim();
    end
    // watchdog, far beyond the expected run length
    initial
    begin
        #1000000;
        num_errors++;
        end_sim();
    end
endmodule // tb_top
`default_nettype wire
